// ---- src/cms_bit_unit.sv ----
// combinational shift, rotate and transfer-flag unit
`timescale 1ns/1ps
module cms_bit_unit import cms_pkg::*; (
  input  wire cms_op_type      op_i,
  input  wire logic [7:0]      operand_i,
  input  wire logic [7:0]      status_register_i,
  input  wire logic [2:0]      bit_sel_i,
  output cms_alu_out_type      alu_o
);

  logic [7:0] res;
  logic [7:0] flags;
  logic       c;

  always_comb begin
    res   = operand_i;
    flags = status_register_i;
    c     = status_register_i[FLAG_C];
    unique case (op_i)
      OP_SHIFT_LEFT_LOGICAL:   {c, res} = {operand_i, 1'b0};
      OP_SHIFT_RIGHT_LOGICAL:  {res, c} = {1'b0, operand_i};
      OP_ROTATE_LEFT_CARRY:    {c, res} = {operand_i, status_register_i[FLAG_C]};
      OP_ROTATE_RIGHT_CARRY:   {res, c} = {status_register_i[FLAG_C], operand_i};
      OP_BIT_TO_TRANSFER_FLAG: flags[FLAG_T] = operand_i[bit_sel_i];
      OP_TRANSFER_FLAG_TO_BIT: res[bit_sel_i] = status_register_i[FLAG_T];
      default: ;
    endcase
    // only z, c, n, v move; s, h, t, i are left as they were
    if (is_shift(op_i)) begin
      flags[FLAG_C] = c;
      flags[FLAG_Z] = (res == 8'h00);
      flags[FLAG_N] = res[7];
      flags[FLAG_V] = res[7] ^ c;
    end
    alu_o.res   = res;
    alu_o.flags = flags;
  end

endmodule

// ---- src/cms_exec.sv ----
// execution slice: program memory, i/o write, stack and bit/shift operations
`timescale 1ns/1ps
module cms_exec import cms_pkg::*; #(
  parameter int unsigned PM_AW = 10,
  parameter int unsigned DM_AW = 8
) (
  input  wire logic            mclk_i,
  input  wire logic            nrst_i,
  input  wire cms_apb_req_type apb_req_i,
  output cms_apb_rsp_type      apb_rsp_o,
  output logic                 busy_o,
  output logic [7:0]           status_register_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0][7:0] gpr;
    logic [63:0][7:0] io;
    logic [7:0]       status_register;
    logic [15:0]      sp;
    cms_cmd_type      cmd;
    logic             busy;
    logic [1:0]       cyc;
    logic [4:0]       reg_sel;
    logic [5:0]       io_sel;
    cms_apb_rsp_type  rsp;
  } cms_state_type;

  cms_state_type   s;
  cms_state_type   next_s;
  cms_alu_out_type alu;
  logic [15:0]     z_ptr;
  logic [15:0]     sp_inc;
  logic [7:0]      operand;
  logic [7:0]      pm_byte;
  logic            last;
  logic            setup;
  logic            access;
  logic            known;
  logic            guarded;
  logic            err;
  logic [31:0]     rd_word;
  logic            pm_we;
  logic [PM_AW-1:0] pm_addr;
  logic [15:0]     pm_wdata;
  logic [15:0]     pm_rdata;
  logic            dm_we;
  logic [DM_AW-1:0] dm_addr;
  logic [7:0]      dm_rdata;

  // ----------------------------------------------------------------
  // memories and bit unit
  // ----------------------------------------------------------------
  cms_mem #(.WIDTH(16), .AW(PM_AW)) u_progmem (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .we_i    (pm_we),
    .addr_i  (pm_addr),
    .wdata_i (pm_wdata),
    .rdata_o (pm_rdata)
  );

  cms_mem #(.WIDTH(8), .AW(DM_AW)) u_stack (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .we_i    (dm_we),
    .addr_i  (dm_addr),
    .wdata_i (operand),
    .rdata_o (dm_rdata)
  );

  cms_bit_unit u_bits (
    .op_i      (s.cmd.op),
    .operand_i (operand),
    .status_register_i    (s.status_register),
    .bit_sel_i (s.cmd.bit_sel),
    .alu_o     (alu)
  );

  // ----------------------------------------------------------------
  // datapath decode
  // ----------------------------------------------------------------
  always_comb begin
    z_ptr    = {s.gpr[Z_HI_REG], s.gpr[Z_LO_REG]};
    sp_inc   = s.sp + 16'h0001;
    operand  = s.gpr[s.cmd.reg_idx];
    last     = s.busy && (s.cyc == (op_cycles(s.cmd.op) - CYC_ONE));
    // address is held for the whole op, so the registered read stays valid
    pm_addr  = z_ptr[PM_AW:1];
    pm_byte  = z_ptr[0] ? pm_rdata[15:8] : pm_rdata[7:0];
    pm_wdata = {s.gpr[1], s.gpr[0]};
    pm_we    = s.busy && (s.cmd.op == OP_PROGMEM_STORE);
    // push writes at sp then decrements; pop pre-increments then reads
    dm_we    = s.busy && (s.cmd.op == OP_STACK_PUSH) && (s.cyc == 2'h0);
    dm_addr  = (s.cmd.op == OP_STACK_PUSH) ? s.sp[DM_AW-1:0] : sp_inc[DM_AW-1:0];
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  always_comb begin
    setup   = apb_req_i.psel && !apb_req_i.penable && !s.rsp.pready;
    access  = apb_req_i.psel && apb_req_i.penable && s.rsp.pready;
    known   = apb_req_i.paddr inside {ADDR_CMD, ADDR_STATUS, ADDR_REG_SEL, ADDR_REG_DATA,
                                      ADDR_STACK_PTR, ADDR_IO_SEL, ADDR_IO_DATA};
    guarded = apb_req_i.paddr inside {ADDR_CMD, ADDR_STATUS, ADDR_REG_DATA,
                                      ADDR_STACK_PTR, ADDR_IO_DATA};
    // writes other than the two select registers mid-operation would race the datapath, so refuse them
    err     = !known || (apb_req_i.pwrite && guarded &&
              (s.busy || ((apb_req_i.paddr == ADDR_CMD) &&
                          (apb_req_i.pwdata[3:0] > OP_LAST_LEGAL))));
    rd_word = 32'h0000_0000;
    unique case (apb_req_i.paddr)
      ADDR_CMD:       rd_word[CMD_W-1:0] = s.cmd;
      ADDR_STATUS:    rd_word = {16'h0000, s.status_register, 7'h00, s.busy};
      ADDR_REG_SEL:   rd_word[4:0] = s.reg_sel;
      ADDR_REG_DATA:  rd_word[7:0] = s.gpr[s.reg_sel];
      ADDR_STACK_PTR: rd_word[15:0] = s.sp;
      ADDR_IO_SEL:    rd_word[5:0] = s.io_sel;
      ADDR_IO_DATA:   rd_word[7:0] = s.io[s.io_sel];
      default:        rd_word = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.rsp.pready  = 1'b0;
    next_s.rsp.pslverr = 1'b0;
    if (setup) begin
      next_s.rsp.pready  = 1'b1;
      next_s.rsp.pslverr = err;
      next_s.rsp.prdata  = (err || apb_req_i.pwrite) ? 32'h0000_0000 : rd_word;
    end
    if (access && apb_req_i.pwrite && !s.rsp.pslverr) begin
      unique case (apb_req_i.paddr)
        ADDR_CMD: begin
          next_s.cmd  = cms_cmd_type'(apb_req_i.pwdata[CMD_W-1:0]);
          next_s.busy = 1'b1;
          next_s.cyc  = 2'h0;
        end
        ADDR_STATUS:    next_s.status_register = apb_req_i.pwdata[STATUS_STATUS_REGISTER_LSB +: 8];
        ADDR_REG_SEL:   next_s.reg_sel = apb_req_i.pwdata[4:0];
        ADDR_REG_DATA:  next_s.gpr[s.reg_sel] = apb_req_i.pwdata[7:0];
        ADDR_STACK_PTR: next_s.sp = apb_req_i.pwdata[15:0];
        ADDR_IO_SEL:    next_s.io_sel = apb_req_i.pwdata[5:0];
        ADDR_IO_DATA:   next_s.io[s.io_sel] = apb_req_i.pwdata[7:0];
        default: ;
      endcase
    end
    if (s.busy) begin
      next_s.cyc = s.cyc + 2'h1;
    end
    if (last) begin
      next_s.busy = 1'b0;
      next_s.cyc  = 2'h0;
      unique case (s.cmd.op)
        OP_PROGMEM_LOAD_R0:  next_s.gpr[0] = pm_byte;
        OP_PROGMEM_LOAD_INC: begin
          next_s.gpr[s.cmd.reg_idx] = pm_byte;
          {next_s.gpr[Z_HI_REG], next_s.gpr[Z_LO_REG]} = z_ptr + 16'h0001;
        end
        OP_PROGMEM_STORE: ;
        OP_IO_WRITE:     next_s.io[s.cmd.io_addr] = operand;
        OP_STACK_PUSH:   next_s.sp = s.sp - 16'h0001;
        OP_STACK_POP: begin
          next_s.gpr[s.cmd.reg_idx] = dm_rdata;
          next_s.sp = sp_inc;
        end
        OP_IO_BIT_SET:   next_s.io[s.cmd.io_addr][s.cmd.bit_sel] = 1'b1;
        OP_IO_BIT_CLEAR: next_s.io[s.cmd.io_addr][s.cmd.bit_sel] = 1'b0;
        OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
        OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY: begin
          next_s.gpr[s.cmd.reg_idx] = alu.res;
          next_s.status_register = alu.flags;
        end
        OP_BIT_TO_TRANSFER_FLAG: next_s.status_register = alu.flags;
        OP_TRANSFER_FLAG_TO_BIT: next_s.gpr[s.cmd.reg_idx] = alu.res;
        default: ;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s      <= '0;
      s.status_register <= STATUS_REGISTER_RESET;
      s.sp   <= SP_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign apb_rsp_o         = s.rsp;
  assign busy_o            = s.busy;
  assign status_register_o = s.status_register;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  AST_PM_LOAD_R0: assert property (
    last && s.cmd.op == OP_PROGMEM_LOAD_R0 |=>
      s.gpr[0] == $past(pm_byte) && s.status_register == $past(s.status_register))
    else $error("program byte load into register 0 wrong");

  AST_PM_LOAD_INC_TIME: assert property (
    $rose(s.busy) && s.cmd.op == OP_PROGMEM_LOAD_INC |-> s.busy [*3] ##1 !s.busy)
    else $error("post-increment load did not take three cycles");

  AST_PM_LOAD_INC_Z: assert property (
    last && s.cmd.op == OP_PROGMEM_LOAD_INC && s.cmd.reg_idx < 5'd30 |=>
      {s.gpr[Z_HI_REG], s.gpr[Z_LO_REG]} == $past(z_ptr) + 16'h0001 &&
      s.gpr[$past(s.cmd.reg_idx)] == $past(pm_byte))
    else $error("post-increment load data or pointer wrong");

  AST_PM_STORE: assert property (
    $rose(s.busy) && s.cmd.op == OP_PROGMEM_STORE |=>
      !s.busy && $stable(s.status_register) ##1 pm_rdata == $past(pm_wdata, 2))
    else $error("program store word or flags wrong");

  AST_IO_WRITE: assert property (
    $rose(s.busy) && s.cmd.op == OP_IO_WRITE |=>
      !s.busy && s.io[$past(s.cmd.io_addr)] == $past(operand))
    else $error("i/o write not done in one cycle");

  AST_PUSH: assert property (
    dm_we |-> dm_addr == s.sp[DM_AW-1:0] ##2 s.sp == $past(s.sp, 2) - 16'h0001)
    else $error("push address or pointer update wrong");

  AST_POP: assert property (
    last && s.cmd.op == OP_STACK_POP |=>
      s.gpr[$past(s.cmd.reg_idx)] == $past(dm_rdata) && s.sp == $past(sp_inc))
    else $error("pop data or pointer update wrong");

  AST_IO_BIT: assert property (
    last && s.cmd.op inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR} |=>
      s.io[$past(s.cmd.io_addr)][$past(s.cmd.bit_sel)] ==
        ($past(s.cmd.op) == OP_IO_BIT_SET) && $stable(s.status_register))
    else $error("i/o bit set or clear wrong");

  AST_SHL: assert property (
    last && s.cmd.op == OP_SHIFT_LEFT_LOGICAL |=>
      s.gpr[$past(s.cmd.reg_idx)] == {$past(operand[6:0]), 1'b0} &&
      s.status_register[FLAG_C] == $past(operand[7]))
    else $error("logical left shift wrong");

  AST_SHR: assert property (
    last && s.cmd.op == OP_SHIFT_RIGHT_LOGICAL |=>
      s.gpr[$past(s.cmd.reg_idx)] == {1'b0, $past(operand[7:1])} && !s.status_register[FLAG_N])
    else $error("logical right shift wrong");

  AST_ROL: assert property (
    last && s.cmd.op == OP_ROTATE_LEFT_CARRY |=>
      s.gpr[$past(s.cmd.reg_idx)][0] == $past(s.status_register[FLAG_C]) &&
      s.status_register[FLAG_V] == (s.status_register[FLAG_N] ^ s.status_register[FLAG_C]))
    else $error("rotate left through carry wrong");

  AST_ROR: assert property (
    last && s.cmd.op == OP_ROTATE_RIGHT_CARRY |=>
      s.gpr[$past(s.cmd.reg_idx)][7] == $past(s.status_register[FLAG_C]) &&
      s.status_register[FLAG_C] == $past(operand[0]) &&
      s.status_register[FLAG_Z] == (s.gpr[$past(s.cmd.reg_idx)] == 8'h00))
    else $error("rotate right through carry wrong");

  AST_BIT_TO_T: assert property (
    last && s.cmd.op == OP_BIT_TO_TRANSFER_FLAG |=>
      s.status_register[FLAG_T] == $past(operand[s.cmd.bit_sel]) &&
      s.status_register[5:0] == $past(s.status_register[5:0]))
    else $error("bit to transfer flag wrong");

  AST_T_TO_BIT: assert property (
    last && s.cmd.op == OP_TRANSFER_FLAG_TO_BIT |=>
      s.gpr[$past(s.cmd.reg_idx)][$past(s.cmd.bit_sel)] == $past(s.status_register[FLAG_T]) &&
      $stable(s.status_register))
    else $error("transfer flag to bit wrong");

  AST_FLAGS_HOLD: assert property (
    s.busy && !is_shift(s.cmd.op) && s.cmd.op != OP_BIT_TO_TRANSFER_FLAG |=>
      $stable(s.status_register))
    else $error("status flags changed by an op that keeps them");

  AST_SHIFT_ONE_CYCLE: assert property (
    $rose(s.busy) && is_shift(s.cmd.op) |=> !s.busy)
    else $error("shift or rotate took more than one cycle");

  AST_SHIFT_FLAGS: assert property (
    last && is_shift(s.cmd.op) |=>
      s.status_register[FLAG_Z] == (s.gpr[$past(s.cmd.reg_idx)] == 8'h00) &&
      s.status_register[FLAG_N] == s.gpr[$past(s.cmd.reg_idx)][7] &&
      s.status_register[FLAG_V] == (s.status_register[FLAG_N] ^ s.status_register[FLAG_C]))
    else $error("shift or rotate flags wrong");

  AST_SHIFT_KEEPS_UPPER: assert property (
    last && is_shift(s.cmd.op) |=> s.status_register[7:4] == $past(s.status_register[7:4]))
    else $error("shift or rotate disturbed an unrelated flag");

  AST_IO_BIT_OTHERS: assert property (
    last && s.cmd.op inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR} |=>
      ((s.io[$past(s.cmd.io_addr)] ^ $past(s.io[s.cmd.io_addr])) &
       ~(8'h01 << $past(s.cmd.bit_sel))) == 8'h00)
    else $error("i/o bit op changed another bit");

  AST_IO_BIT_TIME: assert property (
    $rose(s.busy) && s.cmd.op inside {OP_IO_BIT_SET, OP_IO_BIT_CLEAR} |->
      s.busy [*2] ##1 !s.busy)
    else $error("i/o bit op did not take two cycles");

  AST_T_TO_BIT_OTHERS: assert property (
    last && s.cmd.op == OP_TRANSFER_FLAG_TO_BIT |=>
      ((s.gpr[$past(s.cmd.reg_idx)] ^ $past(operand)) &
       ~(8'h01 << $past(s.cmd.bit_sel))) == 8'h00)
    else $error("transfer flag to bit changed another bit");

  AST_BIT_TO_T_TOP: assert property (
    last && s.cmd.op == OP_BIT_TO_TRANSFER_FLAG |=>
      s.status_register[7] == $past(s.status_register[7]) && s.gpr == $past(s.gpr))
    else $error("bit to transfer flag touched a register or the top flag");

  AST_PUSH_TIME: assert property (
    $rose(s.busy) && s.cmd.op == OP_STACK_PUSH |-> s.busy [*2] ##1 !s.busy)
    else $error("push did not take two cycles");

endmodule

// ---- src/cms_mem.sv ----
// single-port synchronous-read memory used for program and stack storage
`timescale 1ns/1ps
module cms_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned AW    = 8
) (
  input  wire logic             mclk_i,
  input  wire logic             nrst_i,
  input  wire logic             we_i,
  input  wire logic [AW-1:0]    addr_i,
  input  wire logic [WIDTH-1:0] wdata_i,
  output logic      [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem [2**AW];

  // no reset on the array: contents are undefined until written
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[addr_i];
    end
  end

endmodule

// ---- src/cms_pkg.sv ----
// shared constants, types and helpers of the bit/shift/memory execution slice
package cms_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets, one aligned 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD       = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_REG_SEL   = 8'h08;
  localparam logic [7:0] ADDR_REG_DATA  = 8'h0c;
  localparam logic [7:0] ADDR_STACK_PTR = 8'h10;
  localparam logic [7:0] ADDR_IO_SEL    = 8'h14;
  localparam logic [7:0] ADDR_IO_DATA   = 8'h18;

  // ----------------------------------------------------------------
  // status_register bit positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_T = 6;
  localparam int unsigned STATUS_STATUS_REGISTER_LSB = 8;
  localparam logic [7:0]  STATUS_REGISTER_RESET = 8'h00;
  localparam logic [15:0] SP_RESET   = 16'h00ff;
  localparam int unsigned Z_LO_REG   = 30;
  localparam int unsigned Z_HI_REG   = 31;

  // ----------------------------------------------------------------
  // operations and their cycle counts
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_PROGMEM_LOAD_R0          = 4'h0,
    OP_PROGMEM_LOAD_INC         = 4'h1,
    OP_PROGMEM_STORE            = 4'h2,
    OP_IO_WRITE                 = 4'h3,
    OP_STACK_PUSH               = 4'h4,
    OP_STACK_POP                = 4'h5,
    OP_IO_BIT_SET               = 4'h6,
    OP_IO_BIT_CLEAR             = 4'h7,
    OP_SHIFT_LEFT_LOGICAL       = 4'h8,
    OP_SHIFT_RIGHT_LOGICAL      = 4'h9,
    OP_ROTATE_LEFT_CARRY        = 4'ha,
    OP_ROTATE_RIGHT_CARRY       = 4'hb,
    OP_BIT_TO_TRANSFER_FLAG     = 4'hc,
    OP_TRANSFER_FLAG_TO_BIT     = 4'hd
  } cms_op_type;

  localparam logic [3:0] OP_LAST_LEGAL = 4'hd;
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;

  // command word: op in the low nibble
  typedef struct packed {
    logic [2:0] bit_sel;
    logic [5:0] io_addr;
    logic [4:0] reg_idx;
    cms_op_type op;
  } cms_cmd_type;

  localparam int unsigned CMD_W = $bits(cms_cmd_type);

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } cms_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } cms_apb_rsp_type;

  typedef struct packed {
    logic [7:0] res;
    logic [7:0] flags;
  } cms_alu_out_type;

  function automatic logic is_shift(input cms_op_type op);
    return op inside {OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL,
                      OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY};
  endfunction

  function automatic logic [1:0] op_cycles(input cms_op_type op);
    unique case (op)
      OP_PROGMEM_LOAD_R0, OP_PROGMEM_LOAD_INC:          return CYC_THREE;
      OP_STACK_PUSH, OP_STACK_POP,
      OP_IO_BIT_SET, OP_IO_BIT_CLEAR:                   return CYC_TWO;
      default:                                          return CYC_ONE;
    endcase
  endfunction

endpackage

// ---- verification/cms_exec_tb.sv ----
// self-checking bench of the execution slice, driven over apb
`timescale 1ns/1ps
module cms_exec_tb import cms_pkg::*;;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  typedef struct packed {
    cms_op_type op;
    logic [2:0] b;
    logic [7:0] si;
    logic [7:0] di;
    logic [7:0] dout;
    logic [7:0] so;
  } cms_row_type;

  logic            mclk;
  logic            nrst;
  cms_apb_req_type req;
  cms_apb_rsp_type rsp;
  logic            busy;
  logic [7:0]      status_register;
  int              fails;
  int              cmp_count;
  int              nb;
  logic [31:0]     rv;
  logic            er;

  // flags in: c0 z1 n2 v3 t6; upper nibble set in some rows to catch stray flag writes
  cms_row_type rows [12] = '{
    '{OP_SHIFT_LEFT_LOGICAL,   3'h0, 8'hf0, 8'h81, 8'h02, 8'hf9},
    '{OP_SHIFT_LEFT_LOGICAL,   3'h0, 8'h00, 8'h80, 8'h00, 8'h0b},
    '{OP_SHIFT_RIGHT_LOGICAL,  3'h0, 8'hf0, 8'h01, 8'h00, 8'hfb},
    '{OP_SHIFT_RIGHT_LOGICAL,  3'h0, 8'h0f, 8'h80, 8'h40, 8'h00},
    '{OP_ROTATE_LEFT_CARRY,    3'h0, 8'h01, 8'h80, 8'h01, 8'h09},
    '{OP_ROTATE_LEFT_CARRY,    3'h0, 8'h00, 8'h40, 8'h80, 8'h0c},
    '{OP_ROTATE_RIGHT_CARRY,   3'h0, 8'h01, 8'h01, 8'h80, 8'h05},
    '{OP_ROTATE_RIGHT_CARRY,   3'h0, 8'h40, 8'h02, 8'h01, 8'h40},
    '{OP_BIT_TO_TRANSFER_FLAG, 3'h3, 8'h0f, 8'h08, 8'h08, 8'h4f},
    '{OP_BIT_TO_TRANSFER_FLAG, 3'h3, 8'hff, 8'hf7, 8'hf7, 8'hbf},
    '{OP_TRANSFER_FLAG_TO_BIT, 3'h7, 8'h40, 8'h00, 8'h80, 8'h40},
    '{OP_TRANSFER_FLAG_TO_BIT, 3'h0, 8'hbf, 8'hff, 8'hfe, 8'hbf}
  };

  cms_exec cms_exec_i (
    .mclk_i            (mclk),
    .nrst_i            (nrst),
    .apb_req_i         (req),
    .apb_rsp_o         (rsp),
    .busy_o            (busy),
    .status_register_o (status_register)
  );

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (fails == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t ns: saw %h, want %h", $time, seen, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req <= {1'b1, 1'b0, w, a, d};
    @(posedge mclk);
    req.penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (rsp.pready !== 1'b1);
    chk(32'(n), 32'h1);
    rv = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(32'(er), 32'h0);
  endtask

  task automatic setr(input logic [4:0] r, input logic [7:0] v);
    wr(ADDR_REG_SEL, 32'(r));
    wr(ADDR_REG_DATA, 32'(v));
  endtask

  task automatic getr(input logic [4:0] r);
    wr(ADDR_REG_SEL, 32'(r));
    apb(1'b0, ADDR_REG_DATA, 32'h0);
  endtask

  task automatic getio(input logic [5:0] p);
    wr(ADDR_IO_SEL, 32'(p));
    apb(1'b0, ADDR_IO_DATA, 32'h0);
  endtask

  // starts one operation and counts its busy cycles; longest op is 3
  task automatic run(input cms_op_type op, input logic [4:0] r, input logic [5:0] p,
                     input logic [2:0] b);
    wr(ADDR_CMD, 32'(cms_cmd_type'{b, p, r, op}));
    nb = 0;
    repeat (6) begin
      @(posedge mclk);
      if (busy === 1'b1) nb++;
    end
  endtask

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    #100000;
    fails++;
    report_and_stop();
  end

  initial begin
    req = '0;
    nrst = 1'b0;
    fails = 0;
    cmp_count = 0;
    repeat (20) @(posedge mclk);
    nrst <= 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rv, 32'h0);
    apb(1'b0, ADDR_STACK_PTR, 32'h0);
    chk(rv, 32'(SP_RESET));
    foreach (rows[i]) begin
      wr(ADDR_STATUS, {16'h0, rows[i].si, 8'h00});
      setr(5'(i + 2), rows[i].di);
      run(rows[i].op, 5'(i + 2), 6'h0, rows[i].b);
      chk(32'(nb), 32'h1);
      getr(5'(i + 2));
      chk(rv, 32'(rows[i].dout));
      chk(32'(status_register), 32'(rows[i].so));
    end
    // flags parked at a marker that no following op may disturb
    wr(ADDR_STATUS, 32'h5a00);
    setr(5'd3, 8'ha5);
    run(OP_IO_WRITE, 5'd3, 6'h2a, 3'h0);
    chk(32'(nb), 32'h1);
    getio(6'h2a);
    chk(rv, 32'ha5);
    run(OP_IO_BIT_SET, 5'd0, 6'h2a, 3'h1);
    getio(6'h2a);
    chk(rv, 32'ha7);
    run(OP_IO_BIT_CLEAR, 5'd0, 6'h2a, 3'h7);
    getio(6'h2a);
    chk(rv, 32'h27);
    getio(6'h2b);
    chk(rv, 32'h0);
    setr(5'd4, 8'h3c);
    run(OP_STACK_PUSH, 5'd3, 6'h0, 3'h0);
    run(OP_STACK_PUSH, 5'd4, 6'h0, 3'h0);
    apb(1'b0, ADDR_STACK_PTR, 32'h0);
    chk(rv, 32'hfd);
    run(OP_STACK_POP, 5'd9, 6'h0, 3'h0);
    run(OP_STACK_POP, 5'd10, 6'h0, 3'h0);
    getr(5'd9);
    chk(rv, 32'h3c);
    getr(5'd10);
    chk(rv, 32'ha5);
    apb(1'b0, ADDR_STACK_PTR, 32'h0);
    chk(rv, 32'hff);
    setr(5'd0, 8'h11);
    setr(5'd1, 8'h22);
    setr(5'(Z_LO_REG), 8'h04);
    setr(5'(Z_HI_REG), 8'h00);
    run(OP_PROGMEM_STORE, 5'd0, 6'h0, 3'h0);
    setr(5'd0, 8'h00);
    run(OP_PROGMEM_LOAD_R0, 5'd0, 6'h0, 3'h0);
    getr(5'd0);
    chk(rv, 32'h11);
    run(OP_PROGMEM_LOAD_INC, 5'd7, 6'h0, 3'h0);
    chk(32'(nb), 32'h3);
    getr(5'd7);
    chk(rv, 32'h11);
    run(OP_PROGMEM_LOAD_INC, 5'd8, 6'h0, 3'h0);
    getr(5'd8);
    chk(rv, 32'h22);
    getr(5'(Z_LO_REG));
    chk(rv, 32'h06);
    setr(5'(Z_LO_REG), 8'hff);
    run(OP_PROGMEM_STORE, 5'd0, 6'h0, 3'h0);
    run(OP_PROGMEM_LOAD_INC, 5'd7, 6'h0, 3'h0);
    getr(5'd7);
    chk(rv, 32'h22);
    getr(5'(Z_HI_REG));
    chk(rv, 32'h01);
    chk(32'(status_register), 32'h5a);
    // refusals: unmapped, unaligned, bad op, flag write while busy
    apb(1'b1, 8'h1c, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b0, 8'h06, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b1, ADDR_CMD, 32'h0e);
    chk(32'(er), 32'h1);
    // two-cycle op: still busy when the next setup is sampled
    wr(ADDR_CMD, 32'(cms_cmd_type'{3'h3, 6'h2a, 5'd0, OP_IO_BIT_SET}));
    apb(1'b1, ADDR_STATUS, 32'hff00);
    chk(32'(er), 32'h1);
    repeat (6) @(posedge mclk);
    chk(32'(status_register), 32'h5a);
    getio(6'h2a);
    chk(rv, 32'h2f);
    // second reset in mid-run
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rv, 32'h0);
    report_and_stop();
  end

endmodule
